//--- rpm_pkg.sv
package rpm_pkg;

    // Mode strap encoding of the port (bit2, bit1, bit0)
    localparam logic [2:0] RPM_MODE_RESET    = 3'h0;
    localparam int         RPM_MODE_PHY_BIT  = 1;

    // Register byte addresses
    localparam logic [7:0] RPM_ADDR_CONTROL  = 8'h00;
    localparam logic [7:0] RPM_ADDR_STATUS   = 8'h04;
    localparam logic [7:0] RPM_ADDR_STRAPS   = 8'h08;
    localparam logic [7:0] RPM_ADDR_TX_DATA  = 8'h0C;
    localparam logic [7:0] RPM_ADDR_RX_DATA  = 8'h10;

    // Control register fields
    localparam int RPM_CTL_ISOLATE           = 10;
    localparam int RPM_CTL_SPEED_LOW         = 13;
    localparam int RPM_CTL_AUTONEG           = 12;
    localparam int RPM_CTL_DUPLEX            = 8;
    localparam logic [31:0] RPM_CTL_RESET    = 32'h00003100;
    localparam logic [31:0] RPM_CTL_MASK     = 32'h00003500;

    // Status register fields
    localparam int RPM_ST_SPEED              = 0;
    localparam int RPM_ST_DUPLEX             = 1;
    localparam int RPM_ST_PHY_MODE           = 2;
    localparam int RPM_ST_ISOLATED           = 3;
    localparam int RPM_ST_RX_ACTIVE          = 4;
    localparam int RPM_ST_TX_BUSY            = 5;

    localparam logic [1:0] RPM_RESP_OKAY     = 2'h0;
    localparam logic [1:0] RPM_RESP_SLVERR   = 2'h2;

    // Reference clock of the link
    localparam int RPM_REFCLK_MHZ            = 50;
    localparam int RPM_DIBITS_PER_BYTE       = 4;

    typedef struct packed {
        logic [1:0] data;
        logic       valid;
    } rpm_dibit_type;

    typedef struct packed {
        logic speed_pol;
        logic duplex_pol;
        logic [2:0] mode;
    } rpm_strap_type;

    function automatic logic rpm_apply_pol(input logic level, input logic invert);
        return level ^ invert;
    endfunction : rpm_apply_pol

endpackage : rpm_pkg

//--- rpm_port.sv
`timescale 1ns/100ps
module rpm_port
    import rpm_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    input  wire logic        CLOCK_ENABLE,
    input  wire logic        PORT_REFERENCE_CLOCK,
    input  wire logic        PORT_IN_DATA_HI,
    input  wire logic        PORT_IN_DATA_LO,
    input  wire logic        PORT_IN_VALID,
    output logic             PORT_IN_BUFFER_ENABLE,
    output logic             PORT_OUT_DATA_HI,
    output logic             PORT_OUT_DATA_LO,
    output logic             PORT_OUT_VALID,
    output logic             PORT_OUT_ENABLE,
    input  wire logic        PORT_MODE_STRAP_BIT2,
    input  wire logic        PORT_MODE_STRAP_BIT1,
    input  wire logic        PORT_MODE_STRAP_BIT0,
    input  wire logic        SPEED_POL_STRAP,
    input  wire logic        DUPLEX_POL_STRAP,
    input  wire logic        LINK_SPEED_INPUT,
    input  wire logic        LINK_DUPLEX_INPUT,
    output logic             LINK_SPEED,
    output logic             LINK_DUPLEX,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);

    // Reset release seen in the link domain
    logic          link_rst_meta;
    logic          link_rst;
    // Strap capture
    logic          strap_done;
    rpm_strap_type strap;
    // Registers
    logic [31:0]   control;
    logic [7:0]    tx_byte;
    logic          tx_toggle;
    logic [7:0]    rx_byte;
    logic          rx_seen;
    // Live pin synchronisers
    logic [1:0]    speed_sync;
    logic [1:0]    duplex_sync;
    // Controls crossing to the link domain
    logic [1:0]    phy_mode_sync;
    logic [1:0]    iso_sync;
    logic [2:0]    tx_tog_sync;
    // Link-domain state
    rpm_dibit_type in_sample;
    logic [7:0]    link_tx_byte;
    logic [1:0]    tx_count;
    logic          link_tx_busy;
    logic [7:0]    link_rx_shift;
    logic [1:0]    rx_count;
    logic [7:0]    link_rx_byte;
    logic          link_rx_toggle;
    logic          link_rx_active;
    // Link events back in the system domain
    logic [2:0]    rx_tog_sync;
    logic [1:0]    rx_act_sync;
    logic [1:0]    tx_busy_sync;
    // Bus handshake
    logic          aw_held;
    logic          w_held;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          phy_mode;
    logic          isolate;
    logic          next_speed;
    logic          next_duplex;
    logic [31:0]   status;

    assign phy_mode = strap.mode[RPM_MODE_PHY_BIT];
    assign isolate  = control[RPM_CTL_ISOLATE];

    // Straps captured once after reset release
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            strap_done <= 1'b0;
            strap      <= '{speed_pol: 1'b0, duplex_pol: 1'b0, mode: RPM_MODE_RESET};
        end else if (CLOCK_ENABLE && !strap_done) begin
            strap_done <= 1'b1;
            strap      <= '{speed_pol:  SPEED_POL_STRAP,
                            duplex_pol: DUPLEX_POL_STRAP,
                            mode: {PORT_MODE_STRAP_BIT2, PORT_MODE_STRAP_BIT1,
                                   PORT_MODE_STRAP_BIT0}};
        end
    end

    // Live speed and duplex pins
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            speed_sync  <= 2'h0;
            duplex_sync <= 2'h0;
        end else if (CLOCK_ENABLE) begin
            speed_sync  <= {speed_sync[0], LINK_SPEED_INPUT};
            duplex_sync <= {duplex_sync[0], LINK_DUPLEX_INPUT};
        end
    end

    always_comb begin
        if (phy_mode || !control[RPM_CTL_AUTONEG]) begin
            next_speed  = control[RPM_CTL_SPEED_LOW];
            next_duplex = control[RPM_CTL_DUPLEX];
        end else begin
            next_speed  = rpm_apply_pol(speed_sync[1], strap.speed_pol);
            next_duplex = rpm_apply_pol(duplex_sync[1], strap.duplex_pol);
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            LINK_SPEED  <= 1'b0;
            LINK_DUPLEX <= 1'b0;
        end else if (CLOCK_ENABLE) begin
            LINK_SPEED  <= next_speed;
            LINK_DUPLEX <= next_duplex;
        end
    end

    // Link domain: reset release synchroniser
    always_ff @(posedge PORT_REFERENCE_CLOCK or posedge RESET) begin
        if (RESET) begin
            link_rst_meta <= 1'b1;
            link_rst      <= 1'b1;
        end else begin
            link_rst_meta <= !strap_done;
            link_rst      <= link_rst_meta;
        end
    end

    // Link domain: control level synchronisers and transmit toggle
    always_ff @(posedge PORT_REFERENCE_CLOCK or posedge RESET) begin
        if (RESET) begin
            phy_mode_sync <= 2'h0;
            iso_sync      <= 2'h0;
            tx_tog_sync   <= 3'h0;
        end else begin
            phy_mode_sync <= {phy_mode_sync[0], phy_mode};
            iso_sync      <= {iso_sync[0], isolate};
            tx_tog_sync   <= {tx_tog_sync[1:0], tx_toggle};
        end
    end

    // Input buffers off while isolated in PHY mode
    always_ff @(posedge PORT_REFERENCE_CLOCK or posedge RESET) begin
        if (RESET) begin
            PORT_IN_BUFFER_ENABLE <= 1'b1;
        end else begin
            PORT_IN_BUFFER_ENABLE <= !(phy_mode_sync[1] && iso_sync[1]);
        end
    end

    // Rising-edge sample of dibit and valid
    always_ff @(posedge PORT_REFERENCE_CLOCK or posedge RESET) begin
        if (RESET) begin
            in_sample <= '0;
        end else if (PORT_IN_BUFFER_ENABLE) begin
            in_sample <= '{data: {PORT_IN_DATA_HI, PORT_IN_DATA_LO},
                           valid: PORT_IN_VALID};
        end else begin
            in_sample <= '0;
        end
    end

    // Receive assembly, low dibit first
    always_ff @(posedge PORT_REFERENCE_CLOCK or posedge RESET) begin
        if (RESET) begin
            link_rx_shift  <= 8'h00;
            rx_count       <= 2'h0;
            link_rx_byte   <= 8'h00;
            link_rx_toggle <= 1'b0;
            link_rx_active <= 1'b0;
        end else if (link_rst) begin
            rx_count       <= 2'h0;
            link_rx_active <= 1'b0;
        end else begin
            link_rx_active <= in_sample.valid;
            if (in_sample.valid) begin
                link_rx_shift <= {in_sample.data, link_rx_shift[7:2]};
                rx_count      <= rx_count + 2'h1;
                if (rx_count == 2'(RPM_DIBITS_PER_BYTE - 1)) begin
                    link_rx_byte   <= {in_sample.data, link_rx_shift[7:2]};
                    link_rx_toggle <= !link_rx_toggle;
                end
            end else begin
                rx_count <= 2'h0;
            end
        end
    end

    // Transmit serialiser, one byte per system request
    always_ff @(posedge PORT_REFERENCE_CLOCK or posedge RESET) begin
        if (RESET) begin
            link_tx_byte <= 8'h00;
            tx_count     <= 2'h0;
            link_tx_busy <= 1'b0;
        end else if (link_rst) begin
            link_tx_busy <= 1'b0;
        end else if (tx_tog_sync[2] != tx_tog_sync[1] && !link_tx_busy) begin
            link_tx_byte <= tx_byte;
            tx_count     <= 2'h0;
            link_tx_busy <= 1'b1;
        end else if (link_tx_busy) begin
            link_tx_byte <= {2'h0, link_tx_byte[7:2]};
            tx_count     <= tx_count + 2'h1;
            if (tx_count == 2'(RPM_DIBITS_PER_BYTE - 1)) begin
                link_tx_busy <= 1'b0;
            end
        end
    end

    // Output pins: transmit serialiser in both modes, drivers off in link reset and while isolated in PHY mode
    always_ff @(posedge PORT_REFERENCE_CLOCK or posedge RESET) begin
        if (RESET) begin
            PORT_OUT_DATA_HI <= 1'b0;
            PORT_OUT_DATA_LO <= 1'b0;
            PORT_OUT_VALID   <= 1'b0;
            PORT_OUT_ENABLE  <= 1'b0;
        end else begin
            PORT_OUT_DATA_HI <= link_tx_busy & link_tx_byte[1];
            PORT_OUT_DATA_LO <= link_tx_busy & link_tx_byte[0];
            PORT_OUT_VALID   <= link_tx_busy;
            PORT_OUT_ENABLE  <= !link_rst && !(phy_mode_sync[1] && iso_sync[1]);
        end
    end

    // Link events into the system domain
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            rx_tog_sync  <= 3'h0;
            rx_act_sync  <= 2'h0;
            tx_busy_sync <= 2'h0;
        end else if (CLOCK_ENABLE) begin
            rx_tog_sync  <= {rx_tog_sync[1:0], link_rx_toggle};
            rx_act_sync  <= {rx_act_sync[0], link_rx_active};
            tx_busy_sync <= {tx_busy_sync[0], link_tx_busy};
        end
    end

    // Received byte: set wins over the read that clears it
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            rx_byte <= 8'h00;
            rx_seen <= 1'b0;
        end else if (CLOCK_ENABLE) begin
            if (rx_tog_sync[2] != rx_tog_sync[1]) begin
                rx_byte <= link_rx_byte;
                rx_seen <= 1'b1;
            end else if (ARVALID && ARREADY && ARADDR == RPM_ADDR_RX_DATA) begin
                rx_seen <= 1'b0;
            end
        end
    end

    always_comb begin
        status = 32'h0;
        status[RPM_ST_SPEED]     = LINK_SPEED;
        status[RPM_ST_DUPLEX]    = LINK_DUPLEX;
        status[RPM_ST_PHY_MODE]  = phy_mode;
        status[RPM_ST_ISOLATED]  = phy_mode && isolate;
        status[RPM_ST_RX_ACTIVE] = rx_act_sync[1];
        status[RPM_ST_TX_BUSY]   = tx_busy_sync[1];
    end

    // AXI4-Lite write channel
    assign AWREADY = !aw_held && !BVALID;
    assign WREADY  = !w_held && !BVALID;

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0;
            w_strb    <= 4'h0;
            BVALID    <= 1'b0;
            BRESP     <= RPM_RESP_OKAY;
            control   <= RPM_CTL_RESET;
            tx_byte   <= 8'h00;
            tx_toggle <= 1'b0;
        end else if (CLOCK_ENABLE) begin
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                BVALID  <= 1'b1;
                BRESP   <= RPM_RESP_OKAY;
                if (aw_addr == RPM_ADDR_CONTROL) begin
                    for (int b = 0; b < 4; b++) begin
                        if (w_strb[b]) begin
                            control[b*8 +: 8] <= w_data[b*8 +: 8] & RPM_CTL_MASK[b*8 +: 8];
                        end
                    end
                end else if (aw_addr == RPM_ADDR_TX_DATA) begin
                    if (w_strb[0] && !tx_busy_sync[1]) begin
                        tx_byte   <= w_data[7:0];
                        tx_toggle <= !tx_toggle;
                    end
                end else if (aw_addr == RPM_ADDR_STATUS || aw_addr == RPM_ADDR_STRAPS
                             || aw_addr == RPM_ADDR_RX_DATA) begin
                    BRESP <= RPM_RESP_OKAY;
                end else begin
                    BRESP <= RPM_RESP_SLVERR;
                end
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    assign ARREADY = !RVALID;

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            RVALID <= 1'b0;
            RDATA  <= 32'h0;
            RRESP  <= RPM_RESP_OKAY;
        end else if (CLOCK_ENABLE) begin
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RRESP  <= RPM_RESP_OKAY;
                if (ARADDR == RPM_ADDR_CONTROL) begin
                    RDATA <= control;
                end else if (ARADDR == RPM_ADDR_STATUS) begin
                    RDATA <= status;
                end else if (ARADDR == RPM_ADDR_STRAPS) begin
                    RDATA <= {27'h0, strap};
                end else if (ARADDR == RPM_ADDR_TX_DATA) begin
                    RDATA <= {24'h0, tx_byte};
                end else if (ARADDR == RPM_ADDR_RX_DATA) begin
                    RDATA <= {23'h0, rx_seen, rx_byte};
                end else begin
                    RDATA <= 32'h0;
                    RRESP <= RPM_RESP_SLVERR;
                end
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

endmodule : rpm_port

//--- rpm_port_sva.sv
`timescale 1ns/100ps
module rpm_port_sva
    import rpm_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        RESET,
    input wire logic        CLOCK_ENABLE,
    input wire logic        PORT_REFERENCE_CLOCK,
    input wire logic        PORT_IN_BUFFER_ENABLE,
    input wire logic        PORT_OUT_VALID,
    input wire logic        PORT_OUT_ENABLE,
    input wire logic        PORT_MODE_STRAP_BIT1,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic [1:0]  BRESP,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic        RVALID,
    input wire logic        RREADY
);
    AST_WRITE_ANSWER: assert property (@(posedge CLOCK) disable iff (RESET)
        CLOCK_ENABLE && AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write response not raised");
    AST_READ_ANSWER: assert property (@(posedge CLOCK) disable iff (RESET)
        CLOCK_ENABLE && ARVALID && ARREADY |=> RVALID)
        else $error("read response not raised");
    AST_WRITE_HOLD: assert property (@(posedge CLOCK) disable iff (RESET)
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    AST_READ_HOLD: assert property (@(posedge CLOCK) disable iff (RESET)
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read response dropped early");
    AST_READ_REFUSED: assert property (@(posedge CLOCK) disable iff (RESET)
        RVALID |-> !ARREADY)
        else $error("read address taken while busy");
    AST_OUT_BYTE: assert property (@(posedge PORT_REFERENCE_CLOCK) disable iff (RESET)
        $rose(PORT_OUT_VALID) |-> PORT_OUT_VALID [*4])
        else $error("output valid shorter than a byte");
    AST_ISOLATE_DRIVERS: assert property (@(posedge PORT_REFERENCE_CLOCK) disable iff (RESET)
        $fell(PORT_IN_BUFFER_ENABLE) |-> ##[0:2] !PORT_OUT_ENABLE)
        else $error("output drivers left on while isolated");
    AST_BUFFER_MODE: assert property (@(posedge PORT_REFERENCE_CLOCK) disable iff (RESET)
        !PORT_IN_BUFFER_ENABLE |-> PORT_MODE_STRAP_BIT1)
        else $error("input buffers off outside PHY mode");
endmodule : rpm_port_sva

//--- rpm_link_model.sv
`timescale 1ns/100ps
module rpm_link_model (
    input  wire logic ref_clock,
    input  wire logic out_hi,
    input  wire logic out_lo,
    input  wire logic out_valid,
    input  wire logic out_enable,
    output logic      in_hi,
    output logic      in_lo,
    output logic      in_valid
);
    logic [7:0] shift = 8'h00;
    int         cnt   = 0;
    logic [7:0] got_q[$];
    initial {in_hi, in_lo, in_valid} = 3'h0;
    // Low dibit first, valid framing the byte, then pulled-down idle
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clock);
            {in_hi, in_lo, in_valid} <= {b[2*i+1], b[2*i], 1'b1};
        end
        @(posedge ref_clock);
        {in_hi, in_lo, in_valid} <= 3'h0;
    endtask : send
    always @(posedge ref_clock) begin
        if (out_enable && out_valid) begin
            shift = {out_hi, out_lo, shift[7:2]};
            cnt = cnt + 1;
            if (cnt == 4) begin
                got_q.push_back(shift);
                cnt = 0;
            end
        end else begin
            cnt = 0;
        end
    end
endmodule : rpm_link_model

//--- rmii_port_mac_phy_mode_tb_top.sv
`timescale 1ns/100ps
module rmii_port_mac_phy_mode_tb_top import rpm_pkg::*;;
    logic        clock = 1'b0, reset = 1'b1, refclk = 1'b0;
    logic        in_hi, in_lo, in_v, ibe, o_hi, o_lo, o_v, o_en, spd, dup;
    logic [2:0]  mode = 3'h0;
    logic        spol = 1'b0, dpol = 1'b0, sp_in = 1'b0, dp_in = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, b;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, ce = 1'b1;
    logic        awr, wr_rdy, bv, arr, rv;
    logic [31:0] wdata = 32'h0, rdata, r, ctl_m, st, seed = 32'h000121D5;
    logic [1:0]  bresp, rresp, rs;
    int          failures = 0, compares = 0;
    always #2.5 clock = ~clock;
    initial #7 forever #32 refclk = ~refclk;
    rpm_port rpm_port_inst (.CLOCK(clock), .RESET(reset), .CLOCK_ENABLE(ce),
        .PORT_REFERENCE_CLOCK(refclk), .PORT_IN_DATA_HI(in_hi), .PORT_IN_DATA_LO(in_lo),
        .PORT_IN_VALID(in_v), .PORT_IN_BUFFER_ENABLE(ibe), .PORT_OUT_DATA_HI(o_hi),
        .PORT_OUT_DATA_LO(o_lo), .PORT_OUT_VALID(o_v), .PORT_OUT_ENABLE(o_en),
        .PORT_MODE_STRAP_BIT2(mode[2]), .PORT_MODE_STRAP_BIT1(mode[1]),
        .PORT_MODE_STRAP_BIT0(mode[0]), .SPEED_POL_STRAP(spol), .DUPLEX_POL_STRAP(dpol),
        .LINK_SPEED_INPUT(sp_in), .LINK_DUPLEX_INPUT(dp_in), .LINK_SPEED(spd),
        .LINK_DUPLEX(dup), .AWADDR(awaddr), .AWVALID(awv), .AWREADY(awr), .WDATA(wdata),
        .WSTRB(4'hF), .WVALID(wv), .WREADY(wr_rdy), .BRESP(bresp), .BVALID(bv),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arv), .ARREADY(arr), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rv), .RREADY(rready));
    rpm_link_model rpm_link_model_inst (.ref_clock(refclk), .out_hi(o_hi), .out_lo(o_lo),
        .out_valid(o_v), .out_enable(o_en), .in_hi(in_hi), .in_lo(in_lo), .in_valid(in_v));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic wrap_up();
        $display("Summary: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_word
    task automatic chk_bit(input logic g, input logic e);
        chk_word({31'h0, g}, {31'h0, e});
    endtask : chk_bit
    // One bus access; readiness sampled mid-cycle, released after the taking edge
    task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d);
        bit ah, wh, rh, dn;
        int n;
        dn = 0;
        n = 0;
        @(posedge clock);
        if (w) {awaddr, wdata, awv, wv, bready} <= {a, d, 3'h7};
        else {araddr, arv, rready} <= {a, 2'h3};
        while (!dn && n < 200) begin
            @(negedge clock);
            ah = awv && awr;
            wh = wv && wr_rdy;
            rh = arv && arr;
            dn = (bv && bready) || (rv && rready);
            r = rdata;
            rs = w ? bresp : rresp;
            @(posedge clock);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
            if (rh) arv <= 1'b0;
            if (dn) {bready, rready} <= 2'h0;
            n++;
        end
        if (!dn) failures++;
    endtask : acc
    task automatic chk_link(input bit phy);
        repeat (8) @(posedge clock);
        // Pin change while frozen must not reach the output
        ce <= 1'b0;
        sp_in <= ~sp_in;
        repeat (8) @(posedge clock);
        chk_bit(spd, (ctl_m[RPM_CTL_AUTONEG] && !phy) ? ~sp_in ^ spol
                     : ctl_m[RPM_CTL_SPEED_LOW]);
        ce <= 1'b1;
        repeat (8) @(posedge clock);
        chk_bit(spd, (ctl_m[RPM_CTL_AUTONEG] && !phy) ? sp_in ^ spol
                     : ctl_m[RPM_CTL_SPEED_LOW]);
        chk_bit(dup, (ctl_m[RPM_CTL_AUTONEG] && !phy) ? dp_in ^ dpol
                     : ctl_m[RPM_CTL_DUPLEX]);
    endtask : chk_link
    // Byte out through the serialiser and a different byte in from the far side
    task automatic loop_byte(input bit blocked);
        r = xs();
        b = r[7:0];
        acc(1, RPM_ADDR_TX_DATA, {24'h0, b});
        rpm_link_model_inst.send(~b);
        repeat (200) @(posedge clock);
        chk_word(rpm_link_model_inst.got_q.size(), blocked ? 0 : 1);
        if (rpm_link_model_inst.got_q.size() > 0)
            chk_word({24'h0, rpm_link_model_inst.got_q.pop_front()}, {24'h0, b});
        acc(0, RPM_ADDR_RX_DATA, 32'h0);
        chk_bit(r[8], !blocked);
        if (!blocked) chk_word(r, {23'h0, 1'b1, ~b});
    endtask : loop_byte
    initial begin
        for (int p = 0; p < 2; p++) begin
            r = xs();
            reset <= 1'b1;
            {spol, dpol, mode} <= {r[4:2], p[0], r[0]};
            repeat (12) @(posedge clock);
            reset <= 1'b0;
            st = {27'h0, r[4:2], p[0], r[0]};
            ctl_m = RPM_CTL_RESET;
            acc(0, RPM_ADDR_CONTROL, 32'h0);
            chk_word(r, RPM_CTL_RESET);
            acc(0, RPM_ADDR_STRAPS, 32'h0);
            chk_word(r, st);
            acc(0, 8'h40, 32'h0);
            chk_word({30'h0, rs}, {30'h0, RPM_RESP_SLVERR});
            acc(1, 8'h40, 32'h0);
            chk_word({30'h0, rs}, {30'h0, RPM_RESP_SLVERR});
            for (int i = 0; i < 6; i++) begin
                r = xs();
                {sp_in, dp_in} <= r[1:0];
                ctl_m = r & RPM_CTL_MASK & ~(32'h1 << RPM_CTL_ISOLATE);
                acc(1, RPM_ADDR_CONTROL, ctl_m);
                acc(0, RPM_ADDR_CONTROL, 32'h0);
                chk_word(r, ctl_m);
                chk_link(p[0]);
            end
            loop_byte(0);
            ctl_m = RPM_CTL_RESET | (32'h1 << RPM_CTL_ISOLATE);
            acc(1, RPM_ADDR_CONTROL, ctl_m);
            chk_word({30'h0, rs}, {30'h0, RPM_RESP_OKAY});
            repeat (40) @(posedge clock);
            chk_bit(ibe, !p[0]);
            chk_bit(o_en, !p[0]);
            loop_byte(p[0]);
            spol <= ~spol;
            repeat (4) @(posedge clock);
            acc(0, RPM_ADDR_STRAPS, 32'h0);
            chk_word(r, st);
        end
        wrap_up();
    end
    initial begin
        #100000;
        failures++;
        wrap_up();
    end
endmodule : rmii_port_mac_phy_mode_tb_top
bind rpm_port rpm_port_sva rpm_port_sva_inst (.CLOCK, .RESET, .CLOCK_ENABLE,
    .PORT_REFERENCE_CLOCK, .PORT_IN_BUFFER_ENABLE, .PORT_OUT_VALID, .PORT_OUT_ENABLE,
    .PORT_MODE_STRAP_BIT1, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID,
    .BREADY, .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY);
